// *** verilog/cantpc_pkg.sv ***
// Package with shared constants and types for the transceiver pin control ends
package cantpc_pkg;
   localparam int unsigned CLK_PERIOD_NS = 8;
   // Active recessive drive ends at most this long after a transmit rising edge
   localparam int unsigned ACTIVE_RECESSIVE_TIME_NS = 530;
   localparam int unsigned ACTIVE_REC_CYCLES_INT = ACTIVE_RECESSIVE_TIME_NS / CLK_PERIOD_NS;
   localparam logic [7:0] ACTIVE_REC_CYCLES = 8'(ACTIVE_REC_CYCLES_INT);
   // Mask filter time, default figure, in ns
   localparam int unsigned MASK_FILTER_TIME_NS = 1000;
   localparam int unsigned MASK_FILTER_CYCLES_INT = (MASK_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [11:0] MASK_FILTER_CYCLES = 12'(MASK_FILTER_CYCLES_INT);
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [11:0] ZERO12 = 12'h000;

   // Mode select codes on {enable, standby_select_n}
   localparam logic [1:0] SEL_SLEEP = 2'h0;
   localparam logic [1:0] SEL_STANDBY = 2'h1;
   localparam logic [1:0] SEL_GOSLEEP = 2'h2;
   localparam logic [1:0] SEL_NORMAL = 2'h3;
   // Silent mode requested over a separate select bit in this model
   typedef enum logic [4:0] {
      CANTPC_NORMAL = 5'h01,
      CANTPC_SILENT = 5'h02,
      CANTPC_STANDBY = 5'h04,
      CANTPC_GOSLEEP = 5'h08,
      CANTPC_SLEEP = 5'h10
   } cantpc_mode_t;

   typedef enum logic [2:0] {
      CANTPC_TX_PASSIVE = 3'h1,
      CANTPC_TX_DOMINANT = 3'h2,
      CANTPC_TX_ACTIVE_REC = 3'h4
   } cantpc_tx_t;
endpackage : cantpc_pkg

// *** verilog/cantpc_if.sv ***
// Interface joining the transceiver control logic and the protocol controller
`timescale 1ns/100ps
interface cantpc_if;
   logic txd;
   logic txd_oe_n;
   logic rxd;
   logic enable;
   logic standby_select_n;
   logic silent_select;
   logic regulator_control_mask_in;
   logic status_flag_out_n;
   logic status_flag_oe_n;
   modport device (
      input txd, txd_oe_n, enable, standby_select_n, silent_select, regulator_control_mask_in,
      output rxd, status_flag_out_n, status_flag_oe_n
   );
   modport ctrl (
      output txd, txd_oe_n, enable, standby_select_n, silent_select, regulator_control_mask_in,
      input rxd, status_flag_out_n, status_flag_oe_n
   );
endinterface : cantpc_if

// *** verilog/cantpc_device.sv ***
// Transceiver digital pin control: modes, ringing suppression, mask latch, wake and status flag
// Summary of operation
// - Drive recessive strongly after each transmit rise
// - Active recessive ends within 530 ns
// - Then bus driver goes high impedance
// - Floating transmit input reads as recessive
// - Receive output low on power-on or wake
// - Status flag high impedance in sleep
// - Mode inputs default low when undriven
// - Mask input defaults low, regulator enabled
// - Mask high in silent latches regulator disabled
// - Mask latch survives supplies and mode changes
// - Battery undervoltage clears mask latch
// - Mask low in silent re-enables regulator
// - Accepted mask change drives status flag low
// - Controller checks flag high before mask change
// - Leaving silent releases mask acknowledgment
// - Mask unused when regulator powers controller
// - Regulator control on except sleep with no wake pending, off-float
// - Sleep wake pattern or local wake restarts node
// - Local wake on either input edge
// - Faults ORed onto status flag; receive shows wake
`timescale 1ns/100ps
module cantpc_device (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Controller side pins
   cantpc_if.device pins,
   // Supply and bus side
   input wire logic battery_uv_i,
   input wire logic supply_fault_i,
   input wire logic bus_wake_i,
   input wire logic local_wake_i,
   input wire logic bus_rx_i,
   // Bus driver and regulator control
   output logic bus_dominant_o,
   output logic bus_drive_oe_n_o,
   output logic regulator_control_out_o,
   output logic regulator_control_oe_n_o,
   output cantpc_pkg::cantpc_mode_t mode_o
);
   import cantpc_pkg::*;

   cantpc_mode_t mode, next_mode;
   cantpc_tx_t tx_state, next_tx_state;
   logic [7:0] rec_cnt, next_rec_cnt;
   logic [11:0] flt_cnt, next_flt_cnt;
   logic mask_latched, next_mask_latched;
   logic mask_ack, next_mask_ack;
   logic wake_pending, next_wake_pending;
   logic pwr_on, next_pwr_on;
   logic wake_prev, next_wake_prev;
   logic mask_prev, next_mask_prev;
   logic txd_eff, en_eff, stb_eff, mask_eff, silent_eff;
   logic local_wake_edge;
   logic next_bus_dominant, next_bus_oe_n, next_reg_out, next_reg_oe_n;
   logic next_rxd, next_flag_n, next_flag_oe_n;

   always_comb begin
      // Undriven pins take their internal bias
      txd_eff = pins.txd_oe_n ? 1'b1 : pins.txd;
      en_eff = (pins.enable === 1'b1);
      stb_eff = (pins.standby_select_n === 1'b1);
      mask_eff = (pins.regulator_control_mask_in === 1'b1);
      silent_eff = (pins.silent_select === 1'b1);
   end

   assign local_wake_edge = local_wake_i ^ wake_prev;

   // Mode selection and wake handling
   always_comb begin
      next_mode = mode;
      next_wake_pending = wake_pending;
      next_pwr_on = pwr_on;
      next_wake_prev = local_wake_i;
      case (mode)
         CANTPC_SLEEP: begin
            if (bus_wake_i || local_wake_edge) begin
               next_wake_pending = 1'b1;
               next_mode = CANTPC_STANDBY;
            end
         end
         default: begin
            if (silent_eff && en_eff && stb_eff) begin
               next_mode = CANTPC_SILENT;
            end else begin
               case ({en_eff, stb_eff})
                  SEL_NORMAL: next_mode = CANTPC_NORMAL;
                  SEL_STANDBY: next_mode = CANTPC_STANDBY;
                  SEL_GOSLEEP: next_mode = CANTPC_GOSLEEP;
                  default: next_mode = (mode == CANTPC_GOSLEEP) ? CANTPC_SLEEP : CANTPC_STANDBY;
               endcase
            end
            if ((mode != CANTPC_NORMAL) && (bus_wake_i || local_wake_edge)) begin
               next_wake_pending = 1'b1;
            end
         end
      endcase
      if (next_mode == CANTPC_NORMAL) begin
         next_wake_pending = 1'b0;
         next_pwr_on = 1'b0;
      end
   end

   // Ringing suppression on the transmit path
   always_comb begin
      next_tx_state = tx_state;
      next_rec_cnt = rec_cnt;
      if (mode != CANTPC_NORMAL) begin
         next_tx_state = CANTPC_TX_PASSIVE;
         next_rec_cnt = ZERO8;
      end else begin
         case (tx_state)
            CANTPC_TX_PASSIVE: if (!txd_eff) next_tx_state = CANTPC_TX_DOMINANT;
            CANTPC_TX_DOMINANT: begin
               if (txd_eff) begin
                  next_tx_state = CANTPC_TX_ACTIVE_REC;
                  next_rec_cnt = ACTIVE_REC_CYCLES - 8'h02;
               end
            end
            CANTPC_TX_ACTIVE_REC: begin
               if (!txd_eff) next_tx_state = CANTPC_TX_DOMINANT;
               else if (rec_cnt == ZERO8) next_tx_state = CANTPC_TX_PASSIVE;
               else next_rec_cnt = rec_cnt - 8'h01;
            end
            default: next_tx_state = CANTPC_TX_PASSIVE;
         endcase
      end
   end

   // Mask filter, latch and acknowledgment
   always_comb begin
      next_flt_cnt = flt_cnt;
      next_mask_latched = mask_latched;
      next_mask_ack = mask_ack;
      next_mask_prev = mask_eff;
      if (mode != CANTPC_SILENT || mask_eff != mask_prev || mask_eff == mask_latched) begin
         next_flt_cnt = ZERO12;
      end else if (flt_cnt >= MASK_FILTER_CYCLES) begin
         next_mask_latched = mask_eff;
         next_mask_ack = 1'b1;
         next_flt_cnt = ZERO12;
      end else begin
         next_flt_cnt = flt_cnt + 12'h001;
      end
      if (next_mode != CANTPC_SILENT) begin
         next_mask_ack = 1'b0;
      end
      if (battery_uv_i) begin
         next_mask_latched = 1'b0;
      end
   end

   // Pin outputs
   always_comb begin
      next_bus_dominant = (next_tx_state == CANTPC_TX_DOMINANT);
      next_bus_oe_n = (next_tx_state == CANTPC_TX_PASSIVE);
      next_reg_out = !mask_latched || (next_mode == CANTPC_SLEEP && next_wake_pending);
      next_reg_oe_n = (next_mode == CANTPC_SLEEP) && !next_wake_pending;
      if (next_mode == CANTPC_NORMAL) next_rxd = bus_rx_i;
      else next_rxd = !(next_wake_pending || next_pwr_on);
      next_flag_n = !(supply_fault_i || next_mask_ack
         || (next_mode == CANTPC_STANDBY && next_wake_pending)
         || (next_mode == CANTPC_SILENT && next_pwr_on));
      next_flag_oe_n = (next_mode == CANTPC_SLEEP);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode <= CANTPC_STANDBY;
         tx_state <= CANTPC_TX_PASSIVE;
         rec_cnt <= ZERO8;
         flt_cnt <= ZERO12;
         mask_latched <= 1'b0;
         mask_ack <= 1'b0;
         wake_pending <= 1'b1;
         pwr_on <= 1'b1;
         wake_prev <= 1'b0;
         mask_prev <= 1'b0;
         bus_dominant_o <= 1'b0;
         bus_drive_oe_n_o <= 1'b1;
         regulator_control_out_o <= 1'b1;
         regulator_control_oe_n_o <= 1'b0;
         mode_o <= CANTPC_STANDBY;
         pins.rxd <= 1'b0;
         pins.status_flag_out_n <= 1'b0;
         pins.status_flag_oe_n <= 1'b0;
      end else begin
         mode <= next_mode;
         tx_state <= next_tx_state;
         rec_cnt <= next_rec_cnt;
         flt_cnt <= next_flt_cnt;
         mask_latched <= next_mask_latched;
         mask_ack <= next_mask_ack;
         wake_pending <= next_wake_pending;
         pwr_on <= next_pwr_on;
         wake_prev <= next_wake_prev;
         mask_prev <= next_mask_prev;
         bus_dominant_o <= next_bus_dominant;
         bus_drive_oe_n_o <= next_bus_oe_n;
         regulator_control_out_o <= next_reg_out;
         regulator_control_oe_n_o <= next_reg_oe_n;
         mode_o <= next_mode;
         pins.rxd <= next_rxd;
         pins.status_flag_out_n <= next_flag_n;
         pins.status_flag_oe_n <= next_flag_oe_n;
      end
   end
endmodule : cantpc_device

// *** verilog/cantpc_ctrl.sv ***
// Controller end: drives mode, transmit and mask pins from Wishbone registers
`timescale 1ns/100ps
module cantpc_ctrl (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Transmit data stream
   input wire logic tx_bit_i,
   output logic rx_bit_o,
   // Transceiver pins
   cantpc_if.ctrl pins
);
   import cantpc_pkg::*;

   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_STAT = 4'h4;
   localparam int CTRL_EN = 0;
   localparam int CTRL_STB_N = 1;
   localparam int CTRL_SILENT = 2;
   localparam int CTRL_MASK = 3;
   localparam int CTRL_TX_EN = 4;

   logic [4:0] ctrl, next_ctrl;
   logic [31:0] next_dat;
   logic next_ack, next_tx, next_rx;
   logic stat_flag, stat_rxd;
   logic mask_ok;

   assign stat_flag = pins.status_flag_oe_n ? 1'b1 : pins.status_flag_out_n;
   assign stat_rxd = pins.rxd;
   // Mask may only move while the flag is high so its low reads as acknowledgment
   assign mask_ok = stat_flag;

   always_comb begin
      next_ctrl = ctrl;
      next_dat = 32'h0000_0000;
      next_ack = 1'b0;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
         next_ack = 1'b1;
         if (wb_adr_i == ADR_CTRL) begin
            if (wb_we_i && wb_sel_i[0]) begin
               next_ctrl = wb_dat_i[4:0];
               if (!mask_ok) next_ctrl[CTRL_MASK] = ctrl[CTRL_MASK];
            end
            next_dat = {27'h0, ctrl};
         end else if (wb_adr_i == ADR_STAT) begin
            next_dat = {30'h0, stat_rxd, stat_flag};
         end
      end
      // Transmit pin floats while sending is off, so the device must bias it recessive
      next_tx = tx_bit_i;
      next_rx = stat_rxd;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= 5'h02;
         wb_dat_o <= 32'h0000_0000;
         wb_ack_o <= 1'b0;
         rx_bit_o <= 1'b1;
         pins.txd <= 1'b1;
         pins.txd_oe_n <= 1'b1;
         pins.enable <= 1'b0;
         pins.standby_select_n <= 1'b0;
         pins.silent_select <= 1'b0;
         pins.regulator_control_mask_in <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         wb_dat_o <= next_dat;
         wb_ack_o <= next_ack;
         rx_bit_o <= next_rx;
         pins.txd <= next_tx;
         pins.txd_oe_n <= !ctrl[CTRL_TX_EN];
         pins.enable <= ctrl[CTRL_EN];
         pins.standby_select_n <= ctrl[CTRL_STB_N];
         pins.silent_select <= ctrl[CTRL_SILENT];
         pins.regulator_control_mask_in <= ctrl[CTRL_MASK];
      end
   end
endmodule : cantpc_ctrl

// *** dv/cantpc_props.sv ***
// Checker for the pins joining the controller end and the transceiver end
`timescale 1ns/100ps
module cantpc_props (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Interface signals
   input wire logic txd,
   input wire logic txd_oe_n,
   input wire logic rxd,
   input wire logic enable,
   input wire logic standby_select_n,
   input wire logic silent_select,
   input wire logic regulator_control_mask_in,
   input wire logic status_flag_out_n,
   input wire logic status_flag_oe_n
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_normal;
      enable && standby_select_n && !silent_select;
   endsequence
   sequence s_standby;
      !enable && standby_select_n;
   endsequence
   sequence s_silent;
      enable && standby_select_n && silent_select;
   endsequence
   AST_RESET_RXD_LOW: assert property ($fell(rst_i) |-> !rxd)
      else $error("receive line not low after reset");
   AST_RESET_FLAG_LOW: assert property ($fell(rst_i) |-> !status_flag_out_n && !status_flag_oe_n)
      else $error("power-on flag not shown after reset");
   AST_RESET_MASK_LOW: assert property ($fell(rst_i) |-> !regulator_control_mask_in)
      else $error("mask pin not low after reset");
   AST_NORMAL_FLAG_DRIVEN: assert property (s_normal [*4] |-> !status_flag_oe_n)
      else $error("flag floating in normal mode");
   AST_STANDBY_FLAG_DRIVEN: assert property (s_standby [*4] |-> !status_flag_oe_n)
      else $error("flag floating in standby mode");
   AST_FLOAT_CAUSE: assert property ($rose(status_flag_oe_n) |-> !$past(standby_select_n) && !$past(silent_select))
      else $error("flag floated outside sleep selection");
   AST_ACK_RELEASE: assert property (s_silent ##1 s_normal [*3] |-> ##[0:2] status_flag_out_n)
      else $error("flag not released after leaving silent");
   AST_MASK_PIN_GUARD: assert property ($changed(regulator_control_mask_in) |-> $past(status_flag_out_n, 2))
      else $error("mask pin changed while flag was low");
   AST_WAKE_RXD_LOW: assert property ($fell(status_flag_oe_n) |-> !rxd)
      else $error("receive line not low on leaving sleep");
endmodule : cantpc_props

// *** dv/tb.sv ***
// Testbench joining both ends through the pin interface
`timescale 1ns/100ps
module tb;
   import cantpc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [3:0] adr = 4'h0;
   logic [31:0] dat = 32'h0, rdata, q;
   logic tx_bit = 1'b1, rx_bit, uv = 1'b0, sf = 1'b0, bw = 1'b0, lw = 1'b0, brx = 1'b1;
   logic dom, doe_n, rout, roe_n;
   cantpc_mode_t mode;
   int n_errors = 0, total_checks = 0, n, len;
   always #4 clk_i = ~clk_i;
   cantpc_if pins_if ();
   cantpc_ctrl cantpc_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf), .wb_dat_o(rdata), .wb_ack_o(ack), .tx_bit_i(tx_bit),
      .rx_bit_o(rx_bit), .pins(pins_if));
   cantpc_device cantpc_device_inst (.clk_i(clk_i), .rst_i(rst_i), .pins(pins_if), .battery_uv_i(uv),
      .supply_fault_i(sf), .bus_wake_i(bw), .local_wake_i(lw), .bus_rx_i(brx), .bus_dominant_o(dom),
      .bus_drive_oe_n_o(doe_n), .regulator_control_out_o(rout), .regulator_control_oe_n_o(roe_n), .mode_o(mode));
   cantpc_props cantpc_props_inst (.clk_i(clk_i), .rst_i(rst_i), .txd(pins_if.txd), .txd_oe_n(pins_if.txd_oe_n),
      .rxd(pins_if.rxd), .enable(pins_if.enable), .standby_select_n(pins_if.standby_select_n),
      .silent_select(pins_if.silent_select), .regulator_control_mask_in(pins_if.regulator_control_mask_in),
      .status_flag_out_n(pins_if.status_flag_out_n), .status_flag_oe_n(pins_if.status_flag_oe_n));
   function automatic logic [31:0] cw(input logic txen, mask, sil, stbn, en);
      return {27'h0, txen, mask, sil, stbn, en};
   endfunction : cw
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Classic single cycle; waits for ack, read data kept in q
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdata;
      {cyc, stb} <= 2'b00;
      @(posedge clk_i);
   endtask : wb
   task automatic settle(input int c);
      repeat (c) @(posedge clk_i);
   endtask : settle
   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up
   initial begin
      settle(60000);
      n_errors++;
      $display("unexpected watchdog: expected 0 seen 1");
      wrap_up();
   end
   initial begin
      void'($urandom(32'h61c4));
      settle(16);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(0, 4'h0, 32'h0);
      chk("ctrl_reset", 32'h2, q);
      wb(0, 4'h4, 32'h0);
      chk("status_reset", 32'h0, q);
      wb(0, 4'h8, 32'h0);
      chk("unmapped", 32'h0, q);
      chk("reg_out", 1, rout);
      chk("reg_oe_n", 0, roe_n);
      chk("mode", CANTPC_STANDBY, mode);
      $display("test reset finished");
      wb(1, 4'h0, cw(0, 0, 0, 1, 1));
      tx_bit <= 1'b0;
      settle(6);
      chk("float_recessive", 0, dom);
      tx_bit <= 1'b1;
      wb(1, 4'h0, cw(1, 0, 0, 1, 1));
      settle(80);
      for (int i = 0; i < 5; i++) begin
         len = (i == 0) ? 1 : $urandom_range(40, 2);
         tx_bit <= 1'b0;
         settle(len + 3);
         chk("dominant", 1, dom);
         tx_bit <= 1'b1;
         // Count from the edge that first sees the transmit pin high
         n = 0;
         while (pins_if.txd !== 1'b1 && n < 4) begin
            @(posedge clk_i);
            n++;
         end
         n = 0;
         do begin
            @(posedge clk_i);
            n++;
         end while (doe_n !== 1'b1 && n < 200);
         chk("dom_released", 0, dom);
         chk("active_rec", ACTIVE_REC_CYCLES, n);
         chk("passive", 1, doe_n);
      end
      chk("ar_bound", 1, n * CLK_PERIOD_NS <= ACTIVE_RECESSIVE_TIME_NS);
      for (int i = 0; i < 6; i++) begin
         brx <= 1'($urandom);
         settle(4);
         chk("rx_follow", brx, rx_bit);
      end
      for (int i = 0; i < 2; i++) begin
         sf <= (i == 0);
         settle(4);
         wb(0, 4'h4, 32'h0);
         chk("fault_flag", i, q[0]);
      end
      $display("test normal finished");
      // The regulator output powers neither end, so silent stays reachable while masked
      wb(1, 4'h0, cw(0, 0, 1, 1, 1));
      settle(4);
      wb(0, 4'h4, 32'h0);
      chk("flag_before", 1, q[0]);
      wb(1, 4'h0, cw(0, 1, 1, 1, 1));
      wb(1, 4'h0, cw(0, 0, 1, 1, 1));
      settle(MASK_FILTER_CYCLES + 10);
      wb(0, 4'h4, 32'h0);
      chk("short_pulse_flag", 1, q[0]);
      chk("short_pulse_reg", 1, rout);
      wb(1, 4'h0, cw(0, 1, 1, 1, 1));
      settle(MASK_FILTER_CYCLES + 10);
      chk("masked_reg", 0, rout);
      wb(0, 4'h4, 32'h0);
      chk("mask_ack", 0, q[0]);
      wb(1, 4'h0, cw(0, 0, 1, 1, 1));
      wb(0, 4'h0, 32'h0);
      chk("mask_write_held", cw(0, 1, 1, 1, 1), q);
      wb(1, 4'h0, cw(0, 1, 0, 1, 1));
      settle(6);
      wb(0, 4'h4, 32'h0);
      chk("ack_released", 1, q[0]);
      wb(1, 4'h0, cw(0, 0, 0, 1, 1));
      settle(MASK_FILTER_CYCLES + 10);
      chk("latch_kept", 0, rout);
      wb(1, 4'h0, cw(0, 0, 1, 1, 1));
      settle(MASK_FILTER_CYCLES + 10);
      chk("unmasked_reg", 1, rout);
      wb(1, 4'h0, cw(0, 0, 0, 1, 1));
      wb(1, 4'h0, cw(0, 1, 0, 1, 1));
      wb(1, 4'h0, cw(0, 1, 1, 1, 1));
      settle(MASK_FILTER_CYCLES + 10);
      chk("masked_again", 0, rout);
      wb(1, 4'h0, cw(0, 1, 0, 1, 1));
      uv <= 1'b1;
      settle(4);
      uv <= 1'b0;
      settle(6);
      chk("uv_clears_latch", 1, rout);
      $display("test mask finished");
      for (int i = 0; i < 3; i++) begin
         wb(1, 4'h0, cw(0, 0, 0, 0, 1));
         settle(2);
         chk("gosleep_mode", CANTPC_GOSLEEP, mode);
         wb(1, 4'h0, cw(0, 0, 0, 0, 0));
         n = 0;
         while (roe_n !== 1'b1 && n < 5000) begin
            @(posedge clk_i);
            n++;
         end
         chk("sleep_mode", CANTPC_SLEEP, mode);
         chk("flag_float", 1, pins_if.status_flag_oe_n);
         chk("reg_float", 1, roe_n);
         if (i == 2)
            bw <= 1'b1;
         else
            lw <= ~lw;
         n = 0;
         while (roe_n !== 1'b0 && n < 100) begin
            @(posedge clk_i);
            n++;
         end
         bw <= 1'b0;
         chk("woke_mode", CANTPC_STANDBY, mode);
         chk("woke_reg_oe_n", 0, roe_n);
         chk("woke_reg", 1, rout);
         settle(4);
         wb(0, 4'h4, 32'h0);
         chk("wake_rxd", 0, q[1]);
         wb(1, 4'h0, cw(0, 0, 0, 1, 0));
         settle(4);
         chk("standby_mode", CANTPC_STANDBY, mode);
         wb(1, 4'h0, cw(0, 0, 0, 1, 1));
         settle(6);
      end
      $display("test sleep finished");
      wrap_up();
   end
endmodule : tb
